// *** mcfc_codec.sv ***
// Command frame receiver, executor handshake and reply frame sender.
// Assumes a byte receiver and transmitter outside; the executor and
// the program memory sit behind the command port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Transmit only while answering the frame just received.
// - Transceiver drive enable is high only during reply sending.
// - Reply starts only after the executor reports completion, or at once on a bad checksum.
// - Payload is command, type, motor-or-bank and four value bytes.
// - Serial frames add a leading address and trailing checksum, nine bytes.
// - Serial order: address, command, type, bank, value MSB first, checksum.
// - Command checksum is the 8-bit sum of all earlier bytes.
// - In CAN mode no address or checksum bytes are expected.
// - Every accepted command gets exactly one reply.
// - Reply order: reply address, module address, status, command, value, sum.
// - Reply checksum is the 8-bit sum of all earlier reply bytes.
// - In CAN mode the reply omits the reply address and checksum bytes.
// - Status 100 for executed, 101 for stored in program memory.
// - Error statuses 1 to 6 pass through as reported.
// - Program download passes to executor, which stores and later runs it.
module mcfc_codec (
  input  wire logic        i_mclk,
  input  wire logic        i_rstn,
  input  wire logic        i_can_mode,
  input  wire logic [7:0]  i_module_addr,
  input  wire logic [7:0]  i_reply_addr,
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_byte,
  output logic             o_cmd_valid,
  output logic      [7:0]  o_cmd_num,
  output logic      [7:0]  o_cmd_type,
  output logic      [7:0]  o_cmd_bank,
  output logic      [31:0] o_cmd_value,
  input  wire logic        i_exe_done,
  input  wire logic [7:0]  i_exe_status,
  input  wire logic [31:0] i_exe_value,
  output logic             o_tx_valid,
  output logic      [7:0]  o_tx_byte,
  input  wire logic        i_tx_ready,
  output logic             o_tx_en,
  output logic             o_busy
);
  import mcfc_pkg::*;

  // ************************************************************
  // Receive side
  // ************************************************************
  mcfc_state_t state_q;
  logic [3:0]  rx_cnt_q;
  logic [3:0]  tx_cnt_q;
  logic [7:0]  rx_sum;
  logic [7:0]  tx_sum;
  logic        addr_ok_q;
  logic [7:0]  status_q;
  logic [31:0] rvalue_q;
  logic        rx_take;
  logic        rx_last;
  logic        rx_is_sum;
  logic        tx_take;
  logic        tx_last;
  logic [3:0]  tx_pos;
  logic [7:0]  tx_byte_d;

  assign rx_take   = (state_q == MCFC_S_RECV) && i_rx_valid;
  assign rx_last   = rx_cnt_q == (i_can_mode ? MCFC_CNT_LAST_CAN : MCFC_CNT_LAST_SER);
  assign rx_is_sum = !i_can_mode && rx_last;

  mcfc_sum8 u_rx_sum (
    .i_mclk (i_mclk),
    .i_rstn (i_rstn),
    .i_clr  (rx_take && rx_last),
    .i_add  (rx_take && !rx_is_sum),
    .i_byte (i_rx_byte),
    .o_sum  (rx_sum)
  );

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
      rx_cnt_q <= 4'h0;
    else if (rx_take)
      rx_cnt_q <= rx_last ? 4'h0 : rx_cnt_q + 4'h1;
  end

  // Canonical position: serial index, or CAN index shifted past the address
  logic [3:0] rx_pos;
  assign rx_pos = i_can_mode ? rx_cnt_q + 4'h1 : rx_cnt_q;

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_cmd_num   <= MCFC_RST_BYTE;
      o_cmd_type  <= MCFC_RST_BYTE;
      o_cmd_bank  <= MCFC_RST_BYTE;
      o_cmd_value <= 32'h0000_0000;
    end
    else if (rx_take)
    begin
      case (rx_pos)
        4'h1: o_cmd_num   <= i_rx_byte;
        4'h2: o_cmd_type  <= i_rx_byte;
        4'h3: o_cmd_bank  <= i_rx_byte;
        4'h4: o_cmd_value[31:24] <= i_rx_byte;
        4'h5: o_cmd_value[23:16] <= i_rx_byte;
        4'h6: o_cmd_value[15:8]  <= i_rx_byte;
        4'h7: o_cmd_value[7:0]   <= i_rx_byte;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
      addr_ok_q <= 1'b0;
    else if (rx_take && rx_cnt_q == 4'h0)
      addr_ok_q <= i_can_mode || (i_rx_byte == i_module_addr);
  end

  // ************************************************************
  // Frame control
  // ************************************************************
  logic frame_end;
  logic sum_ok;
  logic for_us;
  assign frame_end = rx_take && rx_last;
  assign sum_ok    = i_can_mode || (i_rx_byte == rx_sum);
  // In CAN mode a seven-byte frame never ends on byte 0, so addr_ok_q is set
  assign for_us    = i_can_mode || addr_ok_q;

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
      state_q <= MCFC_S_RECV;
    else
    begin
      case (state_q)
        MCFC_S_RECV:
          if (frame_end && for_us)
            state_q <= sum_ok ? MCFC_S_EXEC : MCFC_S_SEND;
        MCFC_S_EXEC:
          if (i_exe_done)
            state_q <= MCFC_S_SEND;
        MCFC_S_SEND:
          if (tx_take && tx_last)
            state_q <= MCFC_S_RECV;
        default:
          state_q <= MCFC_S_RECV;
      endcase
    end
  end

  // stored-to-memory commands are the executor's business
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_cmd_valid <= 1'b0;
    else
      o_cmd_valid <= frame_end && for_us && sum_ok && (state_q == MCFC_S_RECV);
  end

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      status_q <= MCFC_RST_BYTE;
      rvalue_q <= 32'h0000_0000;
    end
    else if (frame_end && for_us && !sum_ok)
    begin
      status_q <= MCFC_ST_BAD_SUM;
      rvalue_q <= 32'h0000_0000;
    end
    else if (state_q == MCFC_S_EXEC && i_exe_done)
    begin
      status_q <= i_exe_status;
      rvalue_q <= i_exe_value;
    end
  end

  // ************************************************************
  // Transmit side
  // ************************************************************
  assign tx_take = (state_q == MCFC_S_SEND) && i_tx_ready;
  assign tx_last = tx_cnt_q == (i_can_mode ? MCFC_CNT_LAST_CAN : MCFC_CNT_LAST_SER);
  assign tx_pos  = i_can_mode ? tx_cnt_q + 4'h1 : tx_cnt_q;

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
      tx_cnt_q <= 4'h0;
    else if (tx_take)
      tx_cnt_q <= tx_last ? 4'h0 : tx_cnt_q + 4'h1;
  end

  mcfc_sum8 u_tx_sum (
    .i_mclk (i_mclk),
    .i_rstn (i_rstn),
    .i_clr  (tx_take && tx_last),
    .i_add  (tx_take && !tx_last),
    .i_byte (tx_byte_d),
    .o_sum  (tx_sum)
  );

  always_comb
  begin
    case (tx_pos)
      4'h0:    tx_byte_d = i_reply_addr;
      4'h1:    tx_byte_d = i_module_addr;
      4'h2:    tx_byte_d = status_q;
      4'h3:    tx_byte_d = o_cmd_num;
      4'h4:    tx_byte_d = rvalue_q[31:24];
      4'h5:    tx_byte_d = rvalue_q[23:16];
      4'h6:    tx_byte_d = rvalue_q[15:8];
      4'h7:    tx_byte_d = rvalue_q[7:0];
      default: tx_byte_d = tx_sum;
    endcase
  end

  // Byte is a live mux of held registers; stable while tx_valid waits
  assign o_tx_byte  = tx_byte_d;
  assign o_tx_valid = state_q == MCFC_S_SEND;
  assign o_tx_en    = state_q == MCFC_S_SEND;
  assign o_busy     = state_q != MCFC_S_RECV;

  // ************************************************************
  // Checks
  // ************************************************************
  sequence rx_good_s;
    frame_end && for_us && sum_ok && state_q == MCFC_S_RECV;
  endsequence

  tx_only_reply_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    $rose(o_tx_valid) |-> $past(state_q) != MCFC_S_RECV || $past(frame_end))
    else $error("transmit started without a frame");
  drive_release_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_tx_en == (state_q == MCFC_S_SEND))
    else $error("drive enable outside reply");
  exec_first_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    rx_good_s |=> state_q == MCFC_S_EXEC && o_cmd_valid)
    else $error("good frame not executed");
  bad_sum_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    frame_end && for_us && !sum_ok && state_q == MCFC_S_RECV
    |=> state_q == MCFC_S_SEND && status_q == MCFC_ST_BAD_SUM && !o_cmd_valid)
    else $error("bad checksum handled wrongly");
  foreign_drop_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    frame_end && !for_us |=> state_q == MCFC_S_RECV)
    else $error("foreign frame answered");
  sequence reply_end_s;
    tx_take && tx_last;
  endsequence

  // A reply cut short would leave the host waiting with no way to resync
  reply_len_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    $fell(o_tx_valid) |-> $past(tx_take)
      && $past(tx_cnt_q) == (i_can_mode ? MCFC_CNT_LAST_CAN : MCFC_CNT_LAST_SER))
    else $error("reply length wrong");
  reply_sum_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    tx_take && tx_last && !i_can_mode |-> o_tx_byte == tx_sum)
    else $error("reply checksum byte wrong");
  reply_once_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    tx_take && tx_last |=> state_q == MCFC_S_RECV && !o_tx_valid)
    else $error("reply did not end");
  status_pass_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    state_q == MCFC_S_EXEC && i_exe_done |=> status_q == $past(i_exe_status))
    else $error("status not latched");
  reply_head_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    state_q == MCFC_S_SEND && tx_pos == 4'h2 |-> o_tx_byte == status_q)
    else $error("status byte misplaced");
  reply_close_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    reply_end_s |=> !o_busy && tx_cnt_q == 4'h0)
    else $error("reply left state behind");
  cmd_pulse_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_cmd_valid |=> !o_cmd_valid)
    else $error("command strobe longer than one cycle");
  recv_quiet_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    state_q == MCFC_S_RECV |-> !o_tx_valid && !o_tx_en)
    else $error("transmit while receiving");
  exec_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    state_q == MCFC_S_EXEC && !i_exe_done |=> state_q == MCFC_S_EXEC && !o_tx_valid)
    else $error("reply before executor finished");
  reply_addr_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    !i_can_mode && o_tx_valid && tx_cnt_q == 4'h0 |-> o_tx_byte == i_reply_addr)
    else $error("serial reply does not open with reply address");
  can_head_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    i_can_mode && o_tx_valid && tx_cnt_q == 4'h0 |-> o_tx_byte == i_module_addr)
    else $error("CAN reply does not open with module address");
  value_msb_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    rx_take && rx_pos == 4'h4 |=> o_cmd_value[31:24] == $past(i_rx_byte))
    else $error("first value byte not most significant");
  foreign_quiet_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    frame_end && !for_us |=> !o_cmd_valid && !o_busy)
    else $error("foreign frame started work");
  status_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    state_q == MCFC_S_SEND |=> $stable(status_q))
    else $error("status changed during reply");
endmodule : mcfc_codec
`default_nettype wire

// *** mcfc_host_model.sv ***
// Host side model: takes reply bytes from the codec and stores them.
// Assumes one clock; the bench feeds command bytes and clears the store.
`timescale 1ns/1ps
`default_nettype none
module mcfc_host_model (
  input  wire logic       i_mclk,
  input  wire logic       i_rstn,
  input  wire logic       i_slow,
  input  wire logic       i_clr,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_byte,
  output logic            o_tx_ready,
  output logic      [7:0] o_rep [0:8],
  output logic      [3:0] o_rep_cnt
);
  // ************************************************************
  // Reply capture
  // ************************************************************
  // Slow mode stalls every other cycle to stretch the reply
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_tx_ready <= 1'b0;
      o_rep_cnt  <= 4'h0;
    end
    else
    begin
      o_tx_ready <= i_slow ? ~o_tx_ready : 1'b1;
      if (i_tx_valid && o_tx_ready)
      begin
        o_rep[o_rep_cnt] <= i_tx_byte;
        o_rep_cnt        <= o_rep_cnt + 4'h1;
      end
      if (i_clr)
        o_rep_cnt <= 4'h0;
    end
  end
endmodule : mcfc_host_model
`default_nettype wire

// *** mcfc_pkg.sv ***
// Shared constants for the motion command frame codec.
// Assumes one 50 MHz clock; byte streams arrive one byte per strobe.
package mcfc_pkg;

  // ************************************************************
  // Frame layout
  // ************************************************************
  localparam int unsigned MCFC_PAYLOAD_BYTES = 7;
  localparam int unsigned MCFC_SERIAL_BYTES  = 9;
  localparam logic [3:0]  MCFC_CNT_LAST_SER  = 4'h8;
  localparam logic [3:0]  MCFC_CNT_LAST_CAN  = 4'h6;

  // ************************************************************
  // Status codes
  // ************************************************************
  localparam logic [7:0] MCFC_ST_OK       = 8'h64;
  localparam logic [7:0] MCFC_ST_STORED   = 8'h65;
  localparam logic [7:0] MCFC_ST_BAD_SUM  = 8'h01;
  localparam logic [7:0] MCFC_ST_BAD_CMD  = 8'h02;
  localparam logic [7:0] MCFC_ST_BAD_TYPE = 8'h03;
  localparam logic [7:0] MCFC_ST_BAD_VAL  = 8'h04;
  localparam logic [7:0] MCFC_ST_LOCKED   = 8'h05;
  localparam logic [7:0] MCFC_ST_NO_CMD   = 8'h06;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] MCFC_RST_BYTE = 8'h00;

  typedef enum logic [1:0] {
    MCFC_S_RECV = 2'b00,
    MCFC_S_EXEC = 2'b01,
    MCFC_S_SEND = 2'b10
  } mcfc_state_t;

endpackage : mcfc_pkg

// *** mcfc_sum8.sv ***
// Running modulo-256 byte adder used for both frame directions.
// Assumes the caller clears it with the last byte of each frame.
`timescale 1ns/1ps
`default_nettype none
module mcfc_sum8 (
  input  wire logic       i_mclk,
  input  wire logic       i_rstn,
  input  wire logic       i_clr,
  input  wire logic       i_add,
  input  wire logic [7:0] i_byte,
  output logic      [7:0] o_sum
);
  import mcfc_pkg::*;

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_sum <= MCFC_RST_BYTE;
    else if (i_clr)
      o_sum <= MCFC_RST_BYTE;
    else if (i_add)
      o_sum <= o_sum + i_byte;
  end
endmodule : mcfc_sum8
`default_nettype wire

// *** motion_command_frame_codec_tb_top.sv ***
// Self-checking bench for the command frame codec.
// Assumes the host model file and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module motion_command_frame_codec_tb_top;
  import mcfc_pkg::*;
  // ************************************************************
  // Signals and instances
  // ************************************************************
  logic        mclk, rstn, can, rxv, done, slow, clr;
  logic [7:0]  rxb, est;
  logic [31:0] evl;
  logic        cv, txv, txr, txen, busy, tx_seen;
  logic [7:0]  cn, ct, cb, txb;
  logic [31:0] cval;
  logic [7:0]  rep [0:8];
  logic [3:0]  rcnt;
  int          n_errors, comparisons, cyc;
  mcfc_codec i_mcfc_codec (.i_mclk(mclk), .i_rstn(rstn), .i_can_mode(can),
    .i_module_addr(8'h2A), .i_reply_addr(8'h03), .i_rx_valid(rxv), .i_rx_byte(rxb),
    .o_cmd_valid(cv), .o_cmd_num(cn), .o_cmd_type(ct), .o_cmd_bank(cb),
    .o_cmd_value(cval), .i_exe_done(done), .i_exe_status(est), .i_exe_value(evl),
    .o_tx_valid(txv), .o_tx_byte(txb), .i_tx_ready(txr), .o_tx_en(txen), .o_busy(busy));
  mcfc_host_model i_mcfc_host_model (.i_mclk(mclk), .i_rstn(rstn), .i_slow(slow),
    .i_clr(clr), .i_tx_valid(txv), .i_tx_byte(txb), .o_tx_ready(txr),
    .o_rep(rep), .o_rep_cnt(rcnt));
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Run is far shorter than this; a stuck handshake ends here
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (txen)
      tx_seen <= 1'b1;
    if (cyc == 6000)
    begin
      n_errors = n_errors + 1;
      wrap_up();
    end
  end
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons = comparisons + 1;
    if (e !== g)
    begin
      n_errors = n_errors + 1;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic run(input string nm, input logic cm, input logic [7:0] adr,
                     input logic [7:0] st, input logic bad, input logic sl);
    logic [7:0]  f [0:8];
    logic [7:0]  e [0:8];
    logic [31:0] v;
    logic [7:0]  s;
    logic        ok, hit;
    int          n, k;
    v = {8'hA1, st, 8'h5C, 8'h3E};
    f = '{adr, 8'h05, 8'h04, 8'h02, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
    s = 8'h00;
    for (k = 0; k < 8; k++)
      s = s + f[k];
    f[8] = s + {7'h00, bad};
    ok = cm || (adr == 8'h2A);
    @(posedge mclk);
    can <= cm;
    slow <= sl;
    clr <= 1'b1;
    tx_seen <= 1'b0;
    @(posedge mclk);
    clr <= 1'b0;
    for (k = cm; k < (cm ? 8 : 9); k++)
    begin
      @(posedge mclk);
      rxv <= 1'b1;
      rxb <= f[k];
    end
    @(posedge mclk);
    rxv <= 1'b0;
    #1 hit = cv;
    chk("cmd_valid", {31'h0, ok && !bad}, {31'h0, hit});
    chk("busy", {31'h0, ok}, {31'h0, busy});
    if (hit)
    begin
      chk("cmd_fields", {8'h00, 8'h05, 8'h04, 8'h02}, {8'h00, cn, ct, cb});
      chk("cmd_value", v, cval);
      repeat (3) @(posedge mclk);
      chk("early_tx", 32'h0, {31'h0, tx_seen});
      @(posedge mclk);
      done <= 1'b1;
      est <= st;
      evl <= v;
      @(posedge mclk);
      done <= 1'b0;
    end
    if (bad)
    begin
      st = MCFC_ST_BAD_SUM;
      v = 32'h0;
    end
    for (k = 0; k < 80; k++)
    begin
      @(posedge mclk);
      if (!txv && cyc > 0 && k > 4)
        break;
    end
    e = '{8'h03, 8'h2A, st, 8'h05, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
    s = 8'h00;
    for (k = 0; k < 8; k++)
      s = s + e[k];
    e[8] = s;
    n = !ok ? 0 : (cm ? 7 : 9);
    chk("reply_count", n, {28'h0, rcnt});
    for (k = 0; k < n; k++)
      chk("reply_byte", {24'h0, e[k + cm]}, {24'h0, rep[k]});
    chk("tx_en_idle", 32'h0, {31'h0, txen});
    chk("busy_idle", 32'h0, {31'h0, busy});
    $display("Test %s done", nm);
  endtask : run
  task automatic wrap_up();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    n_errors = 0;
    comparisons = 0;
    cyc = 0;
    tx_seen = 1'b0;
    {rstn, can, rxv, done, slow, clr} = 6'h00;
    rxb = 8'h00;
    est = 8'h00;
    evl = 32'h0;
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    run("serial_ok", 1'b0, 8'h2A, MCFC_ST_OK, 1'b0, 1'b0);
    run("stored_slow", 1'b0, 8'h2A, MCFC_ST_STORED, 1'b0, 1'b1);
    for (int i = 2; i < 7; i++)
      run("error_code", 1'b0, 8'h2A, i[7:0], 1'b0, 1'b0);
    run("bad_sum", 1'b0, 8'h2A, MCFC_ST_OK, 1'b1, 1'b0);
    run("other_addr", 1'b0, 8'h2B, MCFC_ST_OK, 1'b0, 1'b0);
    run("can_frame", 1'b1, 8'h77, MCFC_ST_OK, 1'b0, 1'b1);
    wrap_up();
  end
endmodule : motion_command_frame_codec_tb_top
`default_nettype wire
